// file: rtl/ccc_clock_config.v
// clock path selection and pll configuration registers with decoded controls
`timescale 1ns/10ps
`include "ccc_defines.vh"

module ccc_clock_config #(
   parameter ADDR_WIDTH = 8
) (
   // clock and reset
   input  wire                  clock,
   input  wire                  rst,
   // register port
   input  wire [ADDR_WIDTH-1:0] reg_addr,
   input  wire [31:0]           reg_wdata,
   input  wire                  reg_write,
   input  wire                  reg_read,
   output reg  [31:0]           reg_rdata,
   // pll configuration fields
   output wire                  pll_power_on,
   output wire [2:0]            vco_range_and_lock_mode,
   output wire                  extra_feedback_delay,
   output wire [4:0]            feedback_delay_taps,
   output wire [1:0]            feedback_source_select,
   output wire [6:0]            feedback_divider,
   output wire [6:0]            input_divider,
   // pll controls derived from the fields
   output reg  [3:0]            vco_range_onehot_reg,
   output reg                   vco_slow_lock_reg,
   output reg  [3:0]            feedback_source_onehot_reg,
   output reg  [15:0]           feedback_delay_ps_reg,
   output reg  [7:0]            feedback_divide_ratio_reg,
   output reg  [7:0]            input_divide_ratio_reg,
   // path output selector fields
   output wire [2:0]            path_a_output_select,
   output wire [2:0]            path_b_output_select,
   output wire [2:0]            path_c_output_select,
   // decoded path output selects: 0 bypass, 1 input, 2 delay line, 3 global a,
   // 4..7 vco phases 0, 90, 180, 270
   output reg  [7:0]            path_a_output_onehot_reg,
   output reg  [7:0]            path_b_output_onehot_reg,
   output reg  [7:0]            path_c_output_onehot_reg,
   output reg                   path_a_output_invalid_reg,
   // decoded path input selects
   output wire [5:0]            path_a_input_onehot,
   output wire [5:0]            path_b_input_onehot,
   output wire [5:0]            path_c_input_onehot,
   // divider skip controls
   output wire                  path_a_divider_skip,
   output wire                  path_b_divider_skip,
   output wire                  path_c_divider_skip
);

   //-------------------------------------------------------------------------
   // functions
   //-------------------------------------------------------------------------
   // one-hot of a three bit selector code
   function [7:0] onehot8;
      input [2:0] code;
      begin
         onehot8 = 8'h01 << code;
      end
   endfunction

   // divide ratio is the stored field plus one
   function [7:0] div_ratio;
      input [6:0] field;
      begin
         div_ratio = {1'b0, field} + 8'h01;
      end
   endfunction

   // nominal delay of the feedback line in picoseconds
   function [15:0] fb_delay_ps;
      input [4:0] taps;
      input       extra;
      begin
         fb_delay_ps = `CCC_FB_DELAY_BASE_PS + ({11'h000, taps} * `CCC_FB_DELAY_STEP_PS);
         if (extra) begin
            fb_delay_ps = fb_delay_ps + `CCC_XDLY_PS;
         end
      end
   endfunction

   //-------------------------------------------------------------------------
   // register storage
   //-------------------------------------------------------------------------
   reg  [31:0] pll_cfg_reg;
   reg  [31:0] mux_cfg_reg;
   wire        sel_pll;
   wire        sel_mux;
   wire        sel_status;
   wire [2:0]  path_a_src_index;
   wire [2:0]  path_b_src_index;
   wire [2:0]  path_c_src_index;
   wire [31:0] status_word;

   assign sel_pll    = (reg_addr == `CCC_ADDR_PLL_CFG);
   assign sel_mux    = (reg_addr == `CCC_ADDR_MUX_CFG);
   assign sel_status = (reg_addr == `CCC_ADDR_STATUS);

   // the whole pll word is stored, reserved bits included, so that software
   // read-modify-write gets back what it wrote
   always @(posedge clock or posedge rst) begin
      if (rst) begin
         pll_cfg_reg <= `CCC_PLL_CFG_RESET;
      end else if (reg_write && sel_pll) begin
         pll_cfg_reg <= reg_wdata;
      end
   end

   // mux word keeps only the path fields; other bits read as zero
   always @(posedge clock or posedge rst) begin
      if (rst) begin
         mux_cfg_reg <= `CCC_MUX_CFG_RESET;
      end else if (reg_write && sel_mux) begin
         mux_cfg_reg <= reg_wdata & `CCC_MUX_CFG_MASK;
      end
   end

   //-------------------------------------------------------------------------
   // read port
   //-------------------------------------------------------------------------
   // status shows the decoded state that drives the clock muxes
   assign status_word = {16'h0000,
                         pll_cfg_reg[`CCC_PLL_EN_BIT],
                         path_a_output_invalid_reg,
                         1'b0,
                         path_c_src_index,
                         1'b0,
                         path_b_src_index,
                         3'h0,
                         path_a_src_index};

   // data stand in the cycle after the read strobe; unmapped reads give zero
   always @(posedge clock or posedge rst) begin
      if (rst) begin
         reg_rdata <= 32'h00000000;
      end else if (reg_read) begin
         if (sel_pll) begin
            reg_rdata <= pll_cfg_reg;
         end else if (sel_mux) begin
            reg_rdata <= mux_cfg_reg;
         end else if (sel_status) begin
            reg_rdata <= status_word;
         end else begin
            reg_rdata <= 32'h00000000;
         end
      end else begin
         reg_rdata <= 32'h00000000;
      end
   end

   //-------------------------------------------------------------------------
   // pll field outputs
   //-------------------------------------------------------------------------
   // raw fields go straight from the stored word to the analog controls
   assign pll_power_on            = pll_cfg_reg[`CCC_PLL_EN_BIT];
   assign vco_range_and_lock_mode = {pll_cfg_reg[`CCC_VCO_RANGE_HI:`CCC_VCO_RANGE_LO],
                                     pll_cfg_reg[`CCC_VCO_MODE_BIT]};
   assign extra_feedback_delay    = pll_cfg_reg[`CCC_XDLY_BIT];
   assign feedback_delay_taps     = pll_cfg_reg[`CCC_FEEDBACK_DELAY_TAPS_HI:`CCC_FEEDBACK_DELAY_TAPS_LO];
   assign feedback_source_select  = pll_cfg_reg[`CCC_FEEDBACK_SOURCE_SELECT_HI:`CCC_FEEDBACK_SOURCE_SELECT_LO];
   assign feedback_divider        = pll_cfg_reg[`CCC_FEEDBACK_DIVIDER_HI:`CCC_FEEDBACK_DIVIDER_LO];
   assign input_divider           = pll_cfg_reg[`CCC_INPUT_DIVIDER_HI:`CCC_INPUT_DIVIDER_LO];

   //-------------------------------------------------------------------------
   // derived pll controls
   //-------------------------------------------------------------------------
   // registered one cycle behind the fields; the analog side settles far
   // slower than that, so the lag costs nothing
   always @(posedge clock or posedge rst) begin
      if (rst) begin
         vco_range_onehot_reg       <= 4'h1;
         vco_slow_lock_reg          <= 1'b0;
         feedback_source_onehot_reg <= 4'h1;
         feedback_delay_ps_reg      <= `CCC_FB_DELAY_BASE_PS;
         feedback_divide_ratio_reg  <= 8'h01;
         input_divide_ratio_reg     <= 8'h01;
      end else begin
         // bands: 22-43.75, 43.75-87.5, 87.5-175, 175-350 MHz
         vco_range_onehot_reg <= 4'h1 << vco_range_and_lock_mode[2:1];
         // 0 fast lock with high jitter, 1 slow lock with low jitter
         vco_slow_lock_reg <= vco_range_and_lock_mode[0];
         // 0 fabric global b, 1 vco 0, 2 delayed vco 0, 3 path b pos pad
         feedback_source_onehot_reg <= 4'h1 << feedback_source_select;
         feedback_delay_ps_reg <= fb_delay_ps(feedback_delay_taps,
                                              extra_feedback_delay);
         feedback_divide_ratio_reg <= div_ratio(feedback_divider);
         input_divide_ratio_reg    <= div_ratio(input_divider);
      end
   end

   //-------------------------------------------------------------------------
   // path output selectors
   //-------------------------------------------------------------------------
   assign path_a_output_select = mux_cfg_reg[`CCC_A_OSEL_HI:`CCC_A_OSEL_LO];
   assign path_b_output_select = mux_cfg_reg[`CCC_B_OSEL_HI:`CCC_B_OSEL_LO];
   assign path_c_output_select = mux_cfg_reg[`CCC_C_OSEL_HI:`CCC_C_OSEL_LO];

   // path a has nothing behind code 011: its select goes all low and the
   // flag tells software, so no clock is ever routed from a missing input
   always @(posedge clock or posedge rst) begin
      if (rst) begin
         path_a_output_onehot_reg  <= 8'h01;
         path_b_output_onehot_reg  <= 8'h01;
         path_c_output_onehot_reg  <= 8'h01;
         path_a_output_invalid_reg <= 1'b0;
      end else begin
         path_c_output_onehot_reg <= onehot8(path_c_output_select);
         path_b_output_onehot_reg <= onehot8(path_b_output_select);
         if (path_a_output_select == `CCC_OSEL_GLOBAL_A) begin
            path_a_output_onehot_reg  <= 8'h00;
            path_a_output_invalid_reg <= 1'b1;
         end else begin
            path_a_output_onehot_reg  <= onehot8(path_a_output_select);
            path_a_output_invalid_reg <= 1'b0;
         end
      end
   end

   //-------------------------------------------------------------------------
   // path input source decoders
   //-------------------------------------------------------------------------
   // index 5 is the main oscillator on paths a and b
   ccc_src_decode u_path_a_src (
      .clock             (clock),
      .rst               (rst),
      .external_select   (mux_cfg_reg[`CCC_A_EXT_BIT]),
      .dynamic_select    (mux_cfg_reg[`CCC_A_DYN_BIT]),
      .static_select     (mux_cfg_reg[`CCC_A_STAT_BIT]),
      .source_onehot_reg (path_a_input_onehot),
      .source_index_reg  (path_a_src_index)
   );

   ccc_src_decode u_path_b_src (
      .clock             (clock),
      .rst               (rst),
      .external_select   (mux_cfg_reg[`CCC_B_EXT_BIT]),
      .dynamic_select    (mux_cfg_reg[`CCC_B_DYN_BIT]),
      .static_select     (mux_cfg_reg[`CCC_B_STAT_BIT]),
      .source_onehot_reg (path_b_input_onehot),
      .source_index_reg  (path_b_src_index)
   );

   // index 5 is the 32 KHz oscillator on path c
   ccc_src_decode u_path_c_src (
      .clock             (clock),
      .rst               (rst),
      .external_select   (mux_cfg_reg[`CCC_C_EXT_BIT]),
      .dynamic_select    (mux_cfg_reg[`CCC_C_DYN_BIT]),
      .static_select     (mux_cfg_reg[`CCC_C_STAT_BIT]),
      .source_onehot_reg (path_c_input_onehot),
      .source_index_reg  (path_c_src_index)
   );

   //-------------------------------------------------------------------------
   // divider skip controls
   //-------------------------------------------------------------------------
   // clear: global output from the pll divider, set: from the mux path
   assign path_c_divider_skip = mux_cfg_reg[`CCC_C_SKIP_BIT];
   assign path_b_divider_skip = mux_cfg_reg[`CCC_B_SKIP_BIT];
   assign path_a_divider_skip = mux_cfg_reg[`CCC_A_SKIP_BIT];

endmodule

// file: rtl/ccc_defines.vh
// register map, field positions, reset values and delay figures of the clock config block
//----------------------------------------------------------------------------
// Behaviour
// - path C output code picks bypass, path C input, delay line, global A, four VCO phases
// - path C input: neg, pos, diff pad, fabric global, RC or 32 KHz oscillator
// - path B output uses the path C codes, with path B input at 001
// - path B input: neg, pos, diff pad, fabric global, RC or main oscillator
// - path A output like B, but code 011 has no source
// - path A input: neg, pos, diff pad, fabric global, RC or main oscillator
// - PLL enable bit 31: clear powers PLL down, set enables it
// - VCO mode bit 22: 0 fast lock high jitter, 1 slow lock low jitter
// - VCO range bits 24:23 pick one of four output frequency bands
// - extra delay bit 21 adds about 2 ns to the feedback output
// - feedback delay taps 20:16: 535 ps plus 200 ps per step
// - bits 15:14 choose the feedback multiplexer input
// - feedback divider bits 13:7 divide by value plus one
// - input divider bits 6:0 divide by value plus one
// - feedback select: fabric global B, VCO 0, delayed VCO 0, path B pos pad
// - path C skip bit: clear takes divider output, set takes mux path
//----------------------------------------------------------------------------
`ifndef CCC_DEFINES_VH
`define CCC_DEFINES_VH

// register byte addresses
`define CCC_ADDR_PLL_CFG        8'h00
`define CCC_ADDR_MUX_CFG        8'h04
`define CCC_ADDR_STATUS         8'h08

// reset values and writable masks
`define CCC_PLL_CFG_RESET       32'h00000000
`define CCC_MUX_CFG_RESET       32'h00000000
`define CCC_MUX_CFG_MASK        32'h007F7F7F

// pll configuration word fields
`define CCC_PLL_EN_BIT          31
`define CCC_VCO_RANGE_HI        24
`define CCC_VCO_RANGE_LO        23
`define CCC_VCO_MODE_BIT        22
`define CCC_XDLY_BIT            21
`define CCC_FEEDBACK_DELAY_TAPS_HI            20
`define CCC_FEEDBACK_DELAY_TAPS_LO            16
`define CCC_FEEDBACK_SOURCE_SELECT_HI            15
`define CCC_FEEDBACK_SOURCE_SELECT_LO            14
`define CCC_FEEDBACK_DIVIDER_HI            13
`define CCC_FEEDBACK_DIVIDER_LO            7
`define CCC_INPUT_DIVIDER_HI           6
`define CCC_INPUT_DIVIDER_LO           0

// mux configuration word fields
`define CCC_C_SKIP_BIT          22
`define CCC_C_OSEL_HI           21
`define CCC_C_OSEL_LO           19
`define CCC_C_DYN_BIT           18
`define CCC_C_EXT_BIT           17
`define CCC_C_STAT_BIT          16
`define CCC_B_SKIP_BIT          14
`define CCC_B_OSEL_HI           13
`define CCC_B_OSEL_LO           11
`define CCC_B_DYN_BIT           10
`define CCC_B_EXT_BIT           9
`define CCC_B_STAT_BIT          8
`define CCC_A_SKIP_BIT          6
`define CCC_A_OSEL_HI           5
`define CCC_A_OSEL_LO           3
`define CCC_A_DYN_BIT           2
`define CCC_A_EXT_BIT           1
`define CCC_A_STAT_BIT          0

// output selector codes
`define CCC_OSEL_BYPASS         3'h0
`define CCC_OSEL_PATH_IN        3'h1
`define CCC_OSEL_DELAY_LINE     3'h2
`define CCC_OSEL_GLOBAL_A       3'h3

// delay figures in picoseconds
`define CCC_FB_DELAY_BASE_PS    16'h0217
`define CCC_FB_DELAY_STEP_PS    16'h00C8
`define CCC_XDLY_PS             16'h07D0

`endif

// file: rtl/ccc_src_decode.v
// input clock source decoder for one clock path
`timescale 1ns/10ps

module ccc_src_decode (
   // clock and reset
   input  wire       clock,
   input  wire       rst,
   // select bits from the mux configuration word
   input  wire       external_select,
   input  wire       dynamic_select,
   input  wire       static_select,
   // decoded source: 0 neg, 1 pos, 2 diff, 3 fabric, 4 rc, 5 oscillator
   output reg  [5:0] source_onehot_reg,
   output reg  [2:0] source_index_reg
);

   reg [5:0] source_onehot_next;
   reg [2:0] source_index_next;

   //-------------------------------------------------------------------------
   // decode
   //-------------------------------------------------------------------------
   // the static bit is a don't-care once the external bit picks an oscillator
   always @* begin
      source_index_next = 3'h0;
      if (external_select) begin
         source_index_next = dynamic_select ? 3'h5 : 3'h4;
      end else begin
         source_index_next = {1'b0, static_select, dynamic_select};
         if (static_select && !dynamic_select) begin
            source_index_next = 3'h2;
         end else if (!static_select && dynamic_select) begin
            source_index_next = 3'h1;
         end
      end
      source_onehot_next = 6'h01 << source_index_next;
   end

   // registered so the select lines feeding the clock muxes are glitch free
   always @(posedge clock or posedge rst) begin
      if (rst) begin
         source_onehot_reg <= 6'h01;
         source_index_reg  <= 3'h0;
      end else begin
         source_onehot_reg <= source_onehot_next;
         source_index_reg  <= source_index_next;
      end
   end

endmodule

// file: sim/ccc_clock_config_props.sv
// assertion checker for the clock configuration block
`timescale 1ns/10ps

module ccc_clock_config_props #(
   parameter ADDR_WIDTH = 8
) (
   // clock and reset
   input wire                  clock,
   input wire                  rst,
   // register port
   input wire [ADDR_WIDTH-1:0] reg_addr,
   input wire                  reg_read,
   input wire [31:0]           reg_rdata,
   // pll configuration fields
   input wire                  pll_power_on,
   input wire [2:0]            vco_range_and_lock_mode,
   input wire                  extra_feedback_delay,
   input wire [4:0]            feedback_delay_taps,
   input wire [1:0]            feedback_source_select,
   input wire [6:0]            feedback_divider,
   input wire [6:0]            input_divider,
   // derived pll controls
   input wire [3:0]            vco_range_onehot_reg,
   input wire                  vco_slow_lock_reg,
   input wire [3:0]            feedback_source_onehot_reg,
   input wire [15:0]           feedback_delay_ps_reg,
   input wire [7:0]            feedback_divide_ratio_reg,
   input wire [7:0]            input_divide_ratio_reg,
   // path output selectors
   input wire [2:0]            path_a_output_select,
   input wire [2:0]            path_c_output_select,
   input wire [7:0]            path_a_output_onehot_reg,
   input wire [7:0]            path_c_output_onehot_reg,
   input wire                  path_a_output_invalid_reg
);
   // one clock domain, so clock and reset are declared once
   default clocking cb @(posedge clock);
   endclocking
   default disable iff (rst);

   //----------------------------------------------------------------
   // derived controls lag their raw field by exactly one edge
   //----------------------------------------------------------------
   a_vco_range_onehot: assert property (
      vco_range_onehot_reg == (4'h1 << $past(vco_range_and_lock_mode[2:1])))
      else $error("vco range onehot does not follow the range field");
   a_slow_lock_mode: assert property (
      vco_slow_lock_reg == $past(vco_range_and_lock_mode[0]))
      else $error("lock mode flag does not follow its field");
   a_fb_source_onehot: assert property (
      feedback_source_onehot_reg == (4'h1 << $past(feedback_source_select)))
      else $error("feedback source onehot wrong");
   a_fb_delay_ps: assert property (
      feedback_delay_ps_reg == 16'h0217 + 16'h00C8 * $past(feedback_delay_taps)
         + ($past(extra_feedback_delay) ? 16'h07D0 : 16'h0000))
      else $error("feedback delay figure wrong");
   a_fb_divide_ratio: assert property (
      feedback_divide_ratio_reg == {1'b0, $past(feedback_divider)} + 8'h01)
      else $error("feedback divide ratio wrong");
   a_in_divide_ratio: assert property (
      input_divide_ratio_reg == {1'b0, $past(input_divider)} + 8'h01)
      else $error("input divide ratio wrong");
   a_path_c_onehot: assert property (
      path_c_output_onehot_reg == (8'h01 << $past(path_c_output_select)))
      else $error("path c output onehot wrong");
   // code 3 of path a has no source, so nothing may be selected then
   a_path_a_invalid: assert property (
      $past(path_a_output_select) == 3'h3
         |-> path_a_output_invalid_reg && path_a_output_onehot_reg == 8'h00)
      else $error("path a code 3 not flagged");
   //----------------------------------------------------------------
   // read data only in the cycle after a read, and matching the fields
   //----------------------------------------------------------------
   a_rdata_idle_zero: assert property (
      !$past(reg_read) |-> reg_rdata == 32'h0)
      else $error("read data not zero outside a read answer");
   a_pll_read_back: assert property (
      $past(reg_read) && $past(reg_addr) == '0 |-> reg_rdata[31] == pll_power_on
         && reg_rdata[24:0] == {vco_range_and_lock_mode, extra_feedback_delay,
            feedback_delay_taps, feedback_source_select, feedback_divider, input_divider})
      else $error("pll word read back disagrees with field outputs");
endmodule

bind ccc_clock_config ccc_clock_config_props #(.ADDR_WIDTH(ADDR_WIDTH)) u_ccc_clock_config_props (
   .clock(clock), .rst(rst), .reg_addr(reg_addr), .reg_read(reg_read), .reg_rdata(reg_rdata),
   .pll_power_on(pll_power_on), .vco_range_and_lock_mode(vco_range_and_lock_mode),
   .extra_feedback_delay(extra_feedback_delay), .feedback_delay_taps(feedback_delay_taps),
   .feedback_source_select(feedback_source_select), .feedback_divider(feedback_divider),
   .input_divider(input_divider), .vco_range_onehot_reg(vco_range_onehot_reg),
   .vco_slow_lock_reg(vco_slow_lock_reg),
   .feedback_source_onehot_reg(feedback_source_onehot_reg),
   .feedback_delay_ps_reg(feedback_delay_ps_reg),
   .feedback_divide_ratio_reg(feedback_divide_ratio_reg),
   .input_divide_ratio_reg(input_divide_ratio_reg),
   .path_a_output_select(path_a_output_select), .path_c_output_select(path_c_output_select),
   .path_a_output_onehot_reg(path_a_output_onehot_reg),
   .path_c_output_onehot_reg(path_c_output_onehot_reg),
   .path_a_output_invalid_reg(path_a_output_invalid_reg)
);

// file: sim/tb_top.sv
// self-checking testbench for the clock configuration block
`timescale 1ns/10ps

module tb_top;
   //----------------------------------------------------------------
   // signals
   //----------------------------------------------------------------
   logic        clock;
   logic        rst;
   logic [7:0]  reg_addr;
   logic [31:0] reg_wdata;
   logic        reg_write;
   logic        reg_read;
   wire  [31:0] reg_rdata;
   wire  [5:0]  a_in, b_in, c_in;
   wire  [7:0]  a_out, b_out;
   wire  [2:0]  c_sel, b_sel;
   wire         a_inv, skip_a, skip_b, skip_c;
   logic        obs, rd_d, obs_d;
   logic [63:0] exp_q[$];
   logic [63:0] exp_v, got;
   logic [31:0] lfsr, pll_word, mux_word;
   logic [2:0]  k;
   int          n_mismatch, checks_done;

   ccc_clock_config u_ccc_clock_config (
      .clock(clock), .rst(rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
      .reg_write(reg_write), .reg_read(reg_read), .reg_rdata(reg_rdata),
      .pll_power_on(), .vco_range_and_lock_mode(), .extra_feedback_delay(),
      .feedback_delay_taps(), .feedback_source_select(), .feedback_divider(),
      .input_divider(), .vco_range_onehot_reg(), .vco_slow_lock_reg(),
      .feedback_source_onehot_reg(), .feedback_delay_ps_reg(),
      .feedback_divide_ratio_reg(), .input_divide_ratio_reg(),
      .path_a_output_select(), .path_b_output_select(b_sel), .path_c_output_select(c_sel),
      .path_a_output_onehot_reg(a_out), .path_b_output_onehot_reg(b_out),
      .path_c_output_onehot_reg(), .path_a_output_invalid_reg(a_inv),
      .path_a_input_onehot(a_in), .path_b_input_onehot(b_in), .path_c_input_onehot(c_in),
      .path_a_divider_skip(skip_a), .path_b_divider_skip(skip_b), .path_c_divider_skip(skip_c)
   );

   // 20 MHz clock
   always #25 clock = ~clock;

   //----------------------------------------------------------------
   // helpers
   //----------------------------------------------------------------
   function automatic logic [31:0] nxt(input logic [31:0] s);
      return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
   endfunction
   // b is {dynamic, external, static}; external wins over static, and dynamic then picks 5 or 4
   function automatic logic [2:0] src_idx(input logic [2:0] b);
      if (b[1]) return b[2] ? 3'h5 : 3'h4;
      return {1'b0, b[0], b[2]};
   endfunction
   function automatic logic [63:0] exp_obs(input logic [31:0] m);
      return {20'h0, m[13:11], 6'h01 << src_idx(m[18:16]), 6'h01 << src_idx(m[10:8]),
              6'h01 << src_idx(m[2:0]), 8'h01 << m[13:11],
              (m[5:3] == 3'h3) ? 8'h00 : 8'h01 << m[5:3], m[5:3] == 3'h3,
              m[21:19], m[22], m[14], m[6]};
   endfunction
   function automatic logic [31:0] exp_status(input logic [31:0] m, input logic [31:0] p);
      return {16'h0, p[31], m[5:3] == 3'h3, 1'b0, src_idx(m[18:16]), 1'b0,
              src_idx(m[10:8]), 3'h0, src_idx(m[2:0])};
   endfunction

   // one bus cycle; every input is driven once per edge, so strobes may run back to back
   task automatic bus(input logic w, input logic r, input logic o, input logic [7:0] a,
                      input logic [31:0] d);
      @(posedge clock);
      reg_write <= w;
      reg_read  <= r;
      obs       <= o;
      reg_addr  <= a;
      reg_wdata <= d;
   endtask
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      bus(1'b1, 1'b0, 1'b0, a, d);
   endtask
   task automatic rd(input logic [7:0] a, input logic [31:0] e);
      lfsr = nxt(lfsr);
      bus(1'b0, 1'b1, 1'b0, a, lfsr);
      exp_q.push_back({32'h0, e});
   endtask
   task automatic look(input logic [63:0] e);
      bus(1'b0, 1'b0, 1'b1, 8'h00, lfsr);
      exp_q.push_back(e);
   endtask
   task automatic idle(input int n);
      repeat (n) bus(1'b0, 1'b0, 1'b0, 8'h00, lfsr);
   endtask
   task automatic wrap_up();
      if (exp_q.size() != 0) begin
         n_mismatch++;
         $display("[ERR] %0t results never seen %0d", $time, exp_q.size());
      end
      $display("checks %0d mismatches %0d", checks_done, n_mismatch);
      if (n_mismatch == 0 && checks_done > 0)
         $display("TEST PASSED");
      else
         $display("TEST FAILED");
      $finish;
   endtask

   //----------------------------------------------------------------
   // monitor: read data stands only in the cycle after the read edge
   //----------------------------------------------------------------
   always @(posedge clock) begin
      if (rd_d || obs_d) begin
         exp_v = (exp_q.size() != 0) ? exp_q.pop_front() : {64{1'b1}};
         got = rd_d ? {32'h0, reg_rdata}
                    : {20'h0, b_sel, c_in, b_in, a_in, b_out, a_out, a_inv, c_sel,
                       skip_c, skip_b, skip_a};
         checks_done++;
         if (got !== exp_v) begin
            n_mismatch++;
            $display("[ERR] %0t got %h expected %h", $time, got, exp_v);
         end
      end
      rd_d  <= reg_read & ~rst;
      obs_d <= obs & ~rst;
   end

   // watchdog, far beyond the 89 cycles the tests need
   initial begin
      repeat (5000) @(posedge clock);
      n_mismatch++;
      $display("[ERR] %0t watchdog expired", $time);
      wrap_up();
   end

   //----------------------------------------------------------------
   // main sequence
   //----------------------------------------------------------------
   initial begin
      clock = 1'b0;
      rst = 1'b1;
      {reg_addr, reg_wdata, reg_write, reg_read, obs} = '0;
      lfsr = 32'hC0F4;
      pll_word = 32'h0;
      mux_word = 32'h0;
      n_mismatch = 0;
      checks_done = 0;
      repeat (8) @(posedge clock);
      rst <= 1'b0;
      // reset values, unmapped address included
      rd(8'h00, 32'h0);
      rd(8'h04, 32'h0);
      rd(8'h08, 32'h0);
      rd(8'h0C, 32'h0);
      look(exp_obs(32'h0));
      idle(3);
      $display("reset value test done");
      // pll word: all ones first, then random words, each read straight back
      for (int i = 0; i < 8; i++) begin
         lfsr = nxt(lfsr);
         pll_word = (i == 0) ? 32'hFFFFFFFF : lfsr;
         wr(8'h00, pll_word);
         rd(8'h00, pll_word);
      end
      // read-modify-write of the low fields keeps reserved bits 30:25 as read
      pll_word = {pll_word[31:25], ~pll_word[24:0]};
      wr(8'h00, pll_word);
      rd(8'h00, pll_word);
      idle(3);
      $display("pll word test done");
      // every selector code and select combination on each path, junk above the mask
      for (int i = 0; i < 8; i++) begin
         k = i[2:0];
         mux_word = {9'h0, k[0], ~k, k, 1'b0, ~k[0], k, k ^ 3'h5, 1'b0, k[0], k, ~k};
         lfsr = nxt(lfsr);
         wr(8'h04, mux_word | (lfsr & ~32'h007F7F7F));
         rd(8'h04, mux_word);
         rd(8'h08, exp_status(mux_word, pll_word));
         look(exp_obs(mux_word));
      end
      idle(3);
      $display("path select test done");
      // writes to the read-only and unmapped places change nothing
      wr(8'h08, lfsr);
      wr(8'h10, ~lfsr);
      rd(8'h00, pll_word);
      rd(8'h04, mux_word);
      idle(3);
      $display("refused write test done");
      // second reset in mid-run clears everything again
      @(posedge clock);
      rst <= 1'b1;
      repeat (2) @(posedge clock);
      rst <= 1'b0;
      rd(8'h00, 32'h0);
      rd(8'h04, 32'h0);
      look(exp_obs(32'h0));
      idle(4);
      $display("mid-run reset test done");
      wrap_up();
   end
endmodule
